// file: logic/flr_pkg.sv
// shared constants and types for the fault log readout framer
package flr_pkg;
   localparam int unsigned FLR_ADDR_W = 8;
   localparam int unsigned FLR_CHANNELS = 8;
   localparam int unsigned FLR_LOOP_BYTES = 40;
   localparam logic [7:0] FLR_LOOP_TOP = 8'h27;
   localparam logic [7:0] FLR_LOOP4_END = 8'hD8;
   localparam logic [7:0] FLR_LOOP5_START = 8'hD9;
   localparam logic [7:0] FLR_RSVD_BYTE = 8'hE9;
   localparam logic [7:0] FLR_TEMP_STATUS = 8'hEA;
   localparam logic [7:0] FLR_TEMP_HIGH = 8'hEB;
   localparam logic [7:0] FLR_TEMP_LOW = 8'hEC;
   localparam logic [7:0] FLR_LAST_VALID = 8'hED;
   localparam logic [7:0] FLR_RSVD_FIRST = 8'hEE;
   localparam logic [7:0] FLR_LAST_ADDR = 8'hFE;
   localparam logic [7:0] FLR_BLOCK_COUNT = 8'hFF;
   localparam logic [7:0] FLR_ZERO = 8'h00;
   localparam logic [2:0] FLR_TOP_CHANNEL = 3'h7;
   localparam logic [2:0] FLR_CH3 = 3'h3;
   localparam logic [1:0] FLR_SLOT_VENDOR = 2'h0;
   localparam logic [1:0] FLR_SLOT_OUT_STATUS = 2'h1;
   localparam logic [1:0] FLR_SLOT_READ_HIGH = 2'h2;
   localparam logic [1:0] FLR_SLOT_READ_LOW = 2'h3;

   typedef enum logic [1:0] {
      FLR_IDLE = 2'b00,
      FLR_SEND = 2'b01,
      FLR_DONE = 2'b10
   } flr_state_t;
endpackage

// file: logic/flr_src_if.sv
// interface carrying the log store lookup between framer and its mapper
`timescale 1ns/1ps
interface flr_src_if;
   logic [7:0] addr;
   logic [7:0] data;
   logic [5:0] loop_byte;
   modport framer (output addr, input data, input loop_byte);
   modport mapper (input addr, output data, output loop_byte);
endinterface

// file: logic/flr_map.sv
// maps a log address of the final loop and tail onto a stored field byte
`timescale 1ns/1ps
module flr_map
   import flr_pkg::*;
(
   flr_src_if.mapper src,
   input wire logic [flr_pkg::FLR_CHANNELS*8-1:0] i_vendor_status,
   input wire logic [flr_pkg::FLR_CHANNELS*8-1:0] i_out_status,
   input wire logic [flr_pkg::FLR_CHANNELS*16-1:0] i_out_reading,
   input wire logic [7:0] i_temp_status,
   input wire logic [15:0] i_temp_reading,
   input wire logic [7:0] i_early_byte
);
   logic [7:0] off;
   logic [2:0] ch;
   logic [1:0] slot;

   always_comb begin
      off = 8'(src.addr - FLR_LOOP5_START);
      // loop byte count runs down from 39; zero outside the fifth loop
      src.loop_byte = 6'h00;
      if (src.addr >= FLR_LOOP5_START && src.addr <= FLR_LAST_VALID) begin
         src.loop_byte = 6'(FLR_LOOP_TOP - off);
      end
      ch = 3'(FLR_TOP_CHANNEL - off[4:2]);
      slot = off[1:0];
      src.data = FLR_ZERO;
      if (src.addr < FLR_LOOP5_START) begin
         // loops one to four end at 216 and are served by the store
         src.data = i_early_byte;
      end else if (src.addr < FLR_RSVD_BYTE) begin
         case (slot)
            FLR_SLOT_VENDOR: src.data = i_vendor_status[ch*8 +: 8];
            FLR_SLOT_OUT_STATUS: src.data = i_out_status[ch*8 +: 8];
            FLR_SLOT_READ_HIGH: src.data = i_out_reading[ch*16+8 +: 8];
            FLR_SLOT_READ_LOW: src.data = i_out_reading[ch*16 +: 8];
            default: src.data = FLR_ZERO;
         endcase
      end else if (src.addr == FLR_RSVD_BYTE) begin
         src.data = FLR_ZERO;
      end else if (src.addr == FLR_TEMP_STATUS) begin
         src.data = i_temp_status;
      end else if (src.addr == FLR_TEMP_HIGH) begin
         src.data = i_temp_reading[15:8];
      end else if (src.addr == FLR_TEMP_LOW) begin
         src.data = i_temp_reading[7:0];
      end else if (src.addr == FLR_LAST_VALID) begin
         src.data = i_vendor_status[FLR_CH3*8 +: 8];
      end else begin
         src.data = FLR_ZERO;
      end
   end
endmodule

// file: logic/flr_framer.sv
// fault log block read framer: streams log bytes 0x00..0xFE in order
`timescale 1ns/1ps
// How it works
// - each loop is 40 bytes, numbered downward
// - fifth loop starts at 217, channel 7
// - loop byte 23 at 233 is reserved
// - temperature status then reading high, low
// - last valid byte 237 is channel 3 status
// - bytes EE..FE return zero, still sent
// - one block read of 255 bytes
// - fourth loop ends at 216, no gap
module flr_framer
   import flr_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic i_ready,
   input wire logic [flr_pkg::FLR_CHANNELS*8-1:0] i_vendor_status,
   input wire logic [flr_pkg::FLR_CHANNELS*8-1:0] i_out_status,
   input wire logic [flr_pkg::FLR_CHANNELS*16-1:0] i_out_reading,
   input wire logic [7:0] i_temp_status,
   input wire logic [15:0] i_temp_reading,
   input wire logic [7:0] i_early_byte,
   output logic [7:0] o_early_addr,
   output logic [7:0] o_count,
   output logic o_valid,
   output logic [7:0] o_data,
   output logic [7:0] o_addr,
   output logic [5:0] o_loop_byte,
   output logic o_last,
   output logic o_busy
);
   typedef struct packed {
      flr_state_t state;
      logic [7:0] addr;
      logic [7:0] data;
      logic [5:0] loop_byte;
      logic valid;
   } flr_regs_t;

   flr_regs_t r;
   flr_regs_t next_r;
   flr_src_if src();

   flr_map u_map (
      .src(src),
      .i_vendor_status(i_vendor_status),
      .i_out_status(i_out_status),
      .i_out_reading(i_out_reading),
      .i_temp_status(i_temp_status),
      .i_temp_reading(i_temp_reading),
      .i_early_byte(i_early_byte)
   );

   // lookup address is the byte to load next
   logic [7:0] load_addr;
   always_comb begin
      load_addr = (r.state == FLR_IDLE) ? FLR_ZERO : 8'(r.addr + 8'h01);
   end
   assign src.addr = load_addr;
   assign o_early_addr = load_addr;

   always_comb begin
      next_r = r;
      case (r.state)
         FLR_IDLE: begin
            if (i_start) begin
               next_r.state = FLR_SEND;
               next_r.addr = FLR_ZERO;
               next_r.data = src.data;
               next_r.loop_byte = src.loop_byte;
               next_r.valid = 1'b1;
            end
         end
         FLR_SEND: begin
            if (i_ready) begin
               if (r.addr == FLR_LAST_ADDR) begin
                  next_r.state = FLR_DONE;
                  next_r.valid = 1'b0;
                  next_r.data = FLR_ZERO;
               end else begin
                  // no early stop after 0xED: the zero tail is sent too
                  next_r.addr = load_addr;
                  next_r.data = src.data;
                  next_r.loop_byte = src.loop_byte;
               end
            end
         end
         FLR_DONE: begin
            next_r.state = FLR_IDLE;
         end
         default: begin
            next_r.state = FLR_IDLE;
            next_r.valid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         r <= '{state: FLR_IDLE, addr: FLR_ZERO, data: FLR_ZERO,
                loop_byte: 6'h00, valid: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign o_count = FLR_BLOCK_COUNT;
   assign o_valid = r.valid;
   assign o_data = r.data;
   assign o_addr = r.addr;
   // mapper zeroes the loop byte outside the fifth loop, so the port is a plain flop
   assign o_loop_byte = r.loop_byte;
   assign o_last = r.valid && (r.addr == FLR_LAST_ADDR);
   assign o_busy = (r.state != FLR_IDLE);
endmodule

// file: bench/flr_framer_chk.sv
// checker for the fault log block read framer ports
`timescale 1ns/1ps
module flr_framer_chk
   import flr_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic i_ready,
   input wire logic [FLR_CHANNELS*8-1:0] i_vendor_status,
   input wire logic [7:0] i_temp_status,
   input wire logic [7:0] o_count,
   input wire logic o_valid,
   input wire logic [7:0] o_data,
   input wire logic [7:0] o_addr,
   input wire logic [5:0] o_loop_byte,
   input wire logic o_last,
   input wire logic o_busy
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   property p_step;
      o_valid && i_ready && o_addr != 8'hFE |=> o_valid && o_addr == $past(o_addr) + 8'h01;
   endproperty
   a_step: assert property (p_step) else $error("address skipped");
   property p_hold;
      o_valid && !i_ready |=> o_valid && $stable(o_addr) && $stable(o_data);
   endproperty
   a_hold: assert property (p_hold) else $error("byte not held");
   property p_start;
      !o_busy && i_start |=> o_valid && o_addr == 8'h00;
   endproperty
   a_start: assert property (p_start) else $error("block not started at zero");
   property p_tail;
      o_valid && o_addr >= 8'hEE |-> o_data == 8'h00;
   endproperty
   a_tail: assert property (p_tail) else $error("tail byte not zero");
   property p_rsvd;
      o_valid && o_addr == 8'hE9 |-> o_data == 8'h00;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved byte not zero");
   property p_loop;
      o_valid && o_addr >= 8'hD9 && o_addr <= 8'hED |-> o_loop_byte == 6'(9'h100 - o_addr);
   endproperty
   a_loop: assert property (p_loop) else $error("loop byte number wrong");
   property p_ch3;
      o_valid && o_addr == 8'hED |-> o_data == i_vendor_status[31:24];
   endproperty
   a_ch3: assert property (p_ch3) else $error("last valid byte wrong");
   property p_temp;
      o_valid && o_addr == 8'hEA |-> o_data == i_temp_status;
   endproperty
   a_temp: assert property (p_temp) else $error("temperature status wrong");
   property p_end;
      o_last && i_ready |=> !o_valid ##1 !o_busy;
   endproperty
   a_end: assert property (p_end) else $error("block did not close");
   property p_count;
      o_count == 8'hFF && o_last == (o_valid && o_addr == 8'hFE);
   endproperty
   a_count: assert property (p_count) else $error("count or last wrong");
   c_start: cover property (!o_busy && i_start);
   c_stall: cover property (o_valid && !i_ready);
   c_last: cover property (o_last && i_ready);
endmodule
bind flr_framer flr_framer_chk u_flr_framer_chk (.*);

// file: bench/flr_host.sv
// block read host model: takes every offered byte with random stalls
`timescale 1ns/1ps
module flr_host (
   input wire logic i_mclk,
   output logic o_ready
);
   initial o_ready = 1'b0;
   // never ends early: takes tail zeros too
   always @(negedge i_mclk) o_ready <= ($urandom % 4) != 0;
endmodule

// file: bench/test_flr_framer.sv
// self-checking bench for the fault log block read framer
`timescale 1ns/1ps
module test_flr_framer;
   import flr_pkg::*;
   logic i_mclk = 0, i_rst = 1, i_start = 0, i_ready;
   logic [63:0] vs = '0, os = '0;
   logic [127:0] rd = '0;
   logic [7:0] ts = '0, salt = '0, early, o_count, o_data, o_addr, o_early_addr, nxt = '0;
   logic [15:0] tr = '0;
   logic [5:0] o_loop_byte;
   logic o_valid, o_last, o_busy;
   int failures = 0, checked = 0;
   always #10 i_mclk = ~i_mclk;
   assign early = o_early_addr ^ salt;
   flr_host u_flr_host (.i_mclk(i_mclk), .o_ready(i_ready));
   flr_framer u_flr_framer (.i_mclk(i_mclk), .i_rst(i_rst), .i_start(i_start),
      .i_ready(i_ready), .i_vendor_status(vs), .i_out_status(os), .i_out_reading(rd),
      .i_temp_status(ts), .i_temp_reading(tr), .i_early_byte(early),
      .o_early_addr(o_early_addr), .o_count(o_count), .o_valid(o_valid), .o_data(o_data),
      .o_addr(o_addr), .o_loop_byte(o_loop_byte), .o_last(o_last), .o_busy(o_busy));
   task chk(input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %0t got %h want %h", $time, s, e);
      end
   endtask
   task end_of_test;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   function automatic logic [7:0] exp_byte(input logic [7:0] a);
      logic [7:0] k;
      logic [2:0] c;
      k = a - 8'hD9;
      c = 3'h7 - k[4:2];
      if (a <= 8'hD8) return a ^ salt;
      if (a <= 8'hE8) begin
         case (k[1:0])
            2'h0: return vs[c*8+:8];
            2'h1: return os[c*8+:8];
            2'h2: return rd[c*16+8+:8];
            default: return rd[c*16+:8];
         endcase
      end
      if (a == 8'hEA) return ts;
      if (a == 8'hEB) return tr[15:8];
      if (a == 8'hEC) return tr[7:0];
      if (a == 8'hED) return vs[31:24];
      return 8'h00;
   endfunction
   always @(posedge i_mclk) begin
      if (i_rst === 1'b1 || (i_start === 1'b1 && o_busy === 1'b0)) nxt <= 8'h00;
      else if (o_valid === 1'b1 && i_ready === 1'b1) begin
         chk(o_addr, nxt);
         chk({7'h00, o_last}, {7'h00, o_addr == 8'hFE});
         chk({2'b00, o_loop_byte}, (o_addr >= 8'hD9 && o_addr <= 8'hED) ? 8'h00 - o_addr : 8'h00);
         chk(o_data, exp_byte(o_addr));
         nxt <= nxt + 8'h01;
      end
   end
   initial begin
      #(20 * 6000);
      failures++;
      end_of_test;
   end
   initial begin
      void'($urandom(52870));
      repeat (16) @(negedge i_mclk);
      i_rst = 0;
      for (int r = 0; r < 4; r++) begin
         // first read all ones so zero bytes stand out
         for (int i = 0; i < 8; i++) begin
            vs[i*8+:8] = r == 0 ? 8'hFF : 8'($urandom);
            os[i*8+:8] = r == 0 ? 8'hFF : 8'($urandom);
            rd[i*16+:16] = r == 0 ? 16'hFFFF : 16'($urandom);
         end
         {ts, tr, salt} = r == 0 ? 32'hFFFF_FFFF : $urandom;
         // one-cycle start pulse; the edge that takes it clears the byte counter
         i_start = 1;
         @(negedge i_mclk);
         i_start = 0;
         for (int t = 0; t < 2000 && nxt != 8'hFF; t++) @(negedge i_mclk);
         chk(nxt, 8'hFF);
         repeat (3) @(negedge i_mclk);
         chk({7'h00, o_busy}, 8'h00);
         chk(o_count, 8'hFF);
         if (r == 2) begin
            i_start = 1;
            repeat (40) @(negedge i_mclk);
            i_rst = 1;
            i_start = 0;
            @(negedge i_mclk);
            chk({6'h00, o_valid, o_busy}, 8'h00);
            i_rst = 0;
         end
      end
      end_of_test;
   end
endmodule
